// >>> rtl/ifm_top.sv
`timescale 1ns/1ps

module ifm_top
(
  // Clock, reset and freeze
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        clk_en,
  // AHB-Lite slave port
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Peripheral request events, one-cycle pulses on hclk
  input  wire logic        timer1_event,
  input  wire logic        timer0_event,
  input  wire logic        i2c_unit_event,
  input  wire logic        timer3_upper_event,
  input  wire logic        timer1_upper_event,
  input  wire logic        serial_rx_error_event,
  input  wire logic        clocked_serial_ch1_event,
  input  wire logic        clocked_serial_ch0_event,
  // Requests towards the processor core
  output logic      [7:0]  core_request,
  output logic             irq
);

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  ifm_reg_if regs ();

  ifm_ahb_slave u_slave
  (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .clk_en    (clk_en),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hrdata    (hrdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .regs      (regs)
  );

  // ----------------------------------------------------------------
  // Source event vector
  // ----------------------------------------------------------------
  logic [7:0] src_event;

  // Places each source at its fixed bit of the flag register.
  always_comb
  begin
    src_event                               = 8'h00;
    src_event[ifm_pkg::BIT_TIMER1]          = timer1_event;
    src_event[ifm_pkg::BIT_TIMER0]          = timer0_event;
    src_event[ifm_pkg::BIT_I2C_UNIT]        = i2c_unit_event;
    src_event[ifm_pkg::BIT_TIMER3_UPPER]    = timer3_upper_event;
    src_event[ifm_pkg::BIT_TIMER1_UPPER]    = timer1_upper_event;
    src_event[ifm_pkg::BIT_SERIAL_RXERR]    = serial_rx_error_event;
    src_event[ifm_pkg::BIT_CSERIAL_CH1]     = clocked_serial_ch1_event;
    src_event[ifm_pkg::BIT_CSERIAL_CH0]     = clocked_serial_ch0_event;
  end

  // ----------------------------------------------------------------
  // Flag and mask registers
  // ----------------------------------------------------------------
  logic [7:0] request_flags;
  logic [7:0] mask_flags;
  logic [7:0] next_request_flags;
  logic [7:0] next_mask_flags;
  logic [7:0] next_core_request;
  logic       next_irq;

  // Applies software writes, then lets new events set flags.
  // A source event in the same cycle as a clearing write still sets its
  // flag, so a request arriving during the clear is never lost.
  always_comb
  begin
    next_request_flags = request_flags;
    next_mask_flags    = mask_flags;
    if (regs.wr)
    begin
      case (regs.wr_idx)
        // A zero discards a stale request; a one raises it by software.
        ifm_pkg::IFM_IDX_FLAGS:    next_request_flags = regs.wdata;
        // Each mask bit is written on its own, both serial bits included.
        ifm_pkg::IFM_IDX_MASK:     next_mask_flags    = regs.wdata;
        // Writing ones here clears the matching flags.
        ifm_pkg::IFM_IDX_FLAG_CLR: next_request_flags = request_flags & ~regs.wdata;
        default:                   next_request_flags = request_flags;
      endcase
    end
    // Flags are set whatever the mask holds, so a masked request pends.
    next_request_flags = next_request_flags | src_event;
    // The same bit positions gate each flag by its own mask bit.
    next_core_request  = next_request_flags & ~next_mask_flags;
    next_irq           = |next_core_request;
  end

  // Read data follows the values that stand after this cycle's update, so
  // a read right behind a write sees the written value.
  always_comb
  begin
    case (regs.rd_idx)
      ifm_pkg::IFM_IDX_FLAGS:    regs.rdata = next_request_flags;
      ifm_pkg::IFM_IDX_MASK:     regs.rdata = next_mask_flags;
      ifm_pkg::IFM_IDX_FLAG_CLR: regs.rdata = next_request_flags;
      ifm_pkg::IFM_IDX_PENDING:  regs.rdata = next_core_request;
      default:                   regs.rdata = 8'h00;
    endcase
  end

  // Registers flags, masks and the requests forwarded to the core.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      request_flags <= ifm_pkg::RESET_FLAGS;
      mask_flags    <= ifm_pkg::RESET_MASK;
      core_request  <= 8'h00;
      irq           <= 1'b0;
    end
    else if (clk_en)
    begin
      request_flags <= next_request_flags;
      mask_flags    <= next_mask_flags;
      core_request  <= next_core_request;
      irq           <= next_irq;
    end
  end

endmodule : ifm_top

// >>> shared/ifm_pkg.sv
package ifm_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses, one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [31:0] ADDR_FLAGS    = 32'h0000_0000;
  localparam logic [31:0] ADDR_MASK     = 32'h0000_0004;
  localparam logic [31:0] ADDR_FLAG_CLR = 32'h0000_0008;
  localparam logic [31:0] ADDR_PENDING  = 32'h0000_000c;

  // Register index decoded from the byte address.
  typedef enum logic [2:0] {
    IFM_IDX_FLAGS    = 3'h0,
    IFM_IDX_MASK     = 3'h1,
    IFM_IDX_FLAG_CLR = 3'h2,
    IFM_IDX_PENDING  = 3'h3,
    IFM_IDX_NONE     = 3'h4
  } ifm_idx_t;

  // ----------------------------------------------------------------
  // Bit positions, shared by the flag and the mask register
  // ----------------------------------------------------------------
  localparam int unsigned BIT_TIMER1       = 7;
  localparam int unsigned BIT_TIMER0       = 6;
  localparam int unsigned BIT_I2C_UNIT     = 5;
  localparam int unsigned BIT_TIMER3_UPPER = 4;
  localparam int unsigned BIT_TIMER1_UPPER = 3;
  localparam int unsigned BIT_SERIAL_RXERR = 2;
  localparam int unsigned BIT_CSERIAL_CH1  = 1;
  localparam int unsigned BIT_CSERIAL_CH0  = 0;

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int unsigned REG_WIDTH  = 8;
  localparam logic [7:0]  RESET_FLAGS = 8'h00;
  localparam logic [7:0]  RESET_MASK  = 8'hff;

  // Maps a byte address onto a register index.
  function automatic ifm_idx_t ifm_decode(input logic [31:0] addr);
    ifm_idx_t idx;
    idx = IFM_IDX_NONE;
    case (addr)
      ADDR_FLAGS:    idx = IFM_IDX_FLAGS;
      ADDR_MASK:     idx = IFM_IDX_MASK;
      ADDR_FLAG_CLR: idx = IFM_IDX_FLAG_CLR;
      ADDR_PENDING:  idx = IFM_IDX_PENDING;
      default:       idx = IFM_IDX_NONE;
    endcase
    return idx;
  endfunction : ifm_decode

endpackage : ifm_pkg

// >>> shared/ifm_reg_if.sv
`timescale 1ns/1ps
interface ifm_reg_if;

  logic                 wr;
  ifm_pkg::ifm_idx_t    wr_idx;
  logic [7:0]           wdata;
  ifm_pkg::ifm_idx_t    rd_idx;
  logic [7:0]           rdata;

  // Bus side issues writes and read selects.
  modport bus_side  (output wr, output wr_idx, output wdata, output rd_idx, input rdata);
  // Register side applies writes and returns read data.
  modport regs_side (input wr, input wr_idx, input wdata, input rd_idx, output rdata);

endinterface : ifm_reg_if

// >>> rtl/ifm_ahb_slave.sv
`timescale 1ns/1ps
module ifm_ahb_slave
(
  // Clock, reset and freeze
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        clk_en,
  // AHB-Lite slave port
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Register side
  ifm_reg_if.bus_side      regs
);

  // ----------------------------------------------------------------
  // Address phase capture
  // ----------------------------------------------------------------
  logic              wr_pend;
  ifm_pkg::ifm_idx_t wr_idx_q;
  logic              next_wr_pend;
  ifm_pkg::ifm_idx_t next_wr_idx;
  logic [31:0]       next_hrdata;
  logic              addr_ok;

  // A transfer is taken when selected, NONSEQ or SEQ, and the bus is ready.
  // Only whole-word transfers are expected, so hsize is not decoded.
  always_comb
  begin
    addr_ok      = hsel && htrans[1] && hready;
    next_wr_pend = addr_ok && hwrite;
    next_wr_idx  = addr_ok ? ifm_pkg::ifm_decode(haddr) : ifm_pkg::IFM_IDX_NONE;
    next_hrdata  = hrdata;
    if (addr_ok && !hwrite)
    begin
      next_hrdata = {24'h00_0000, regs.rdata};
    end
  end

  // The read select is live in the address phase; the answer is registered.
  assign regs.rd_idx = ifm_pkg::ifm_decode(haddr);
  // Writes take effect in the data phase with hwdata.
  assign regs.wr     = wr_pend;
  assign regs.wr_idx = wr_idx_q;
  assign regs.wdata  = hwdata[7:0];

  // Registers the bus state; the slave never inserts wait states.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend   <= 1'b0;
      wr_idx_q  <= ifm_pkg::IFM_IDX_NONE;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else if (clk_en)
    begin
      wr_pend   <= next_wr_pend;
      wr_idx_q  <= next_wr_idx;
      hrdata    <= next_hrdata;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

endmodule : ifm_ahb_slave

// >>> bench/ifm_top_asserts.sv
`timescale 1ns/1ps
module ifm_top_asserts
(
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        clk_en,
  // Bus side
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Requests
  input wire logic [7:0]  core_request,
  input wire logic        irq
);
  logic take;
  logic wdp;
  logic next_wdp;
  // A write in its data phase is the only way a request may drop.
  assign take = hsel & htrans[1] & hready & clk_en;
  always_comb next_wdp = clk_en ? (take & hwrite) : wdp;
  // Registers the data-phase marker.
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      wdp <= 1'b0;
    else
      wdp <= next_wdp;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_irq_tracks_req: assert property (irq == (|core_request))
    else $error("irq differs from requests");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("error response seen");
  a_ready_kept: assert property (take |=> hreadyout [*2])
    else $error("wait state inserted");
  a_upper_zero: assert property (hrdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  a_req_holds: assert property (!$past(wdp) |-> ($past(core_request) & ~core_request) == 8'h00)
    else $error("request dropped without a write");
  a_rdata_stable: assert property (!$past(take & ~hwrite) |-> $stable(hrdata))
    else $error("read data changed without a read");
  a_irq_fall_write: assert property ($fell(irq) |-> $past(wdp))
    else $error("irq fell without a write");
  a_unmapped_zero: assert property (take && !hwrite && haddr >= 32'h10 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
endmodule : ifm_top_asserts

// >>> bench/ifm_src_model.sv
`timescale 1ns/1ps
module ifm_src_model
(
  // Clock
  input wire logic       hclk,
  // Request lines, bit 7 down to bit 0
  output logic     [7:0] evt
);
  // Lines rest low between requests.
  initial evt = 8'h00;
  // Raises the chosen requests for exactly one clock cycle.
  task automatic pulse(input logic [7:0] bits);
    evt <= bits;
    @(posedge hclk);
    evt <= 8'h00;
  endtask : pulse
endmodule : ifm_src_model

// >>> bench/ifm_top_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin failures++; $display("FAIL t=%0t got=%h exp=%h", $time, (g), (e)); end end
module ifm_top_tb;
  logic        hclk;
  logic        hresetn;
  logic        clk_en;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [7:0]  evt;
  logic [7:0]  core_request;
  logic        irq;
  logic [31:0] rd;
  int          failures;
  int          total_checks;
  // Free-running 100 MHz clock.
  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  ifm_top dut_u (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .timer1_event(evt[7]),
    .timer0_event(evt[6]), .i2c_unit_event(evt[5]), .timer3_upper_event(evt[4]),
    .timer1_upper_event(evt[3]), .serial_rx_error_event(evt[2]),
    .clocked_serial_ch1_event(evt[1]), .clocked_serial_ch0_event(evt[0]),
    .core_request(core_request), .irq(irq));
  ifm_src_model src_u (.hclk(hclk), .evt(evt));
  // Prints the counts and the verdict, then stops.
  task automatic finish_test();
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  // Waits for hready high at a rising edge, giving up after 20 edges.
  task automatic wait_rdy();
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1)
    begin
      failures++;
      finish_test();
    end
  endtask : wait_rdy
  // One single-word transfer: address phase, then data phase.
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask : xfer
  // Reads a word and compares it.
  task automatic rchk(input logic [31:0] a, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0);
    `CHK(rd, e)
  endtask : rchk
  // Reset, then the register and request sequences.
  initial
  begin
    failures = 0;
    total_checks = 0;
    hresetn = 1'b0;
    clk_en = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rchk(ifm_pkg::ADDR_FLAGS, 32'h0);
    rchk(ifm_pkg::ADDR_MASK, 32'h0000_00ff);
    xfer(32'h0000_0010, 1'b1, 32'h0000_0000);
    rchk(32'h0000_0010, 32'h0);
    rchk(ifm_pkg::ADDR_MASK, 32'h0000_00ff);
    // Each source alone: held while masked, forwarded once enabled, then cleared.
    for (int b = 0; b < 8; b++)
    begin
      xfer(ifm_pkg::ADDR_FLAGS, 1'b1, 32'h0);
      src_u.pulse(8'h01 << b);
      rchk(ifm_pkg::ADDR_FLAGS, 32'h1 << b);
      `CHK(irq, 1'b0)
      xfer(ifm_pkg::ADDR_MASK, 1'b1, ~(32'h1 << b));
      rchk(ifm_pkg::ADDR_PENDING, 32'h1 << b);
      `CHK({irq, core_request}, {1'b1, 8'h01 << b})
      xfer(ifm_pkg::ADDR_FLAG_CLR, 1'b1, 32'h1 << b);
      rchk(ifm_pkg::ADDR_FLAGS, 32'h0);
      `CHK({irq, core_request}, 9'h000)
      xfer(ifm_pkg::ADDR_MASK, 1'b1, 32'h0000_00ff);
    end
    // Both clocked-serial channels enabled together, then disabled together.
    xfer(ifm_pkg::ADDR_MASK, 1'b1, 32'h0000_00fc);
    src_u.pulse(8'h03);
    rchk(ifm_pkg::ADDR_PENDING, 32'h3);
    xfer(ifm_pkg::ADDR_MASK, 1'b1, 32'h0000_00ff);
    rchk(ifm_pkg::ADDR_PENDING, 32'h0);
    rchk(ifm_pkg::ADDR_FLAGS, 32'h3);
    xfer(ifm_pkg::ADDR_FLAGS, 1'b1, 32'h0);
    rchk(ifm_pkg::ADDR_FLAGS, 32'h0);
    `CHK(irq, 1'b0)
    // An event that arrives while clk_en is low is never taken.
    xfer(ifm_pkg::ADDR_MASK, 1'b1, 32'h0000_007f);
    clk_en <= 1'b0;
    src_u.pulse(8'h80);
    clk_en <= 1'b1;
    rchk(ifm_pkg::ADDR_FLAGS, 32'h0);
    `CHK(irq, 1'b0)
    // An event in the data phase of a clearing write keeps its flag set.
    fork
      xfer(ifm_pkg::ADDR_FLAG_CLR, 1'b1, 32'h0000_0080);
      begin
        @(posedge hclk);
        src_u.pulse(8'h80);
      end
    join
    rchk(ifm_pkg::ADDR_FLAG_CLR, 32'h0000_0080);
    `CHK({irq, core_request}, 9'h180)
    // A reset in mid-run returns flags, masks and outputs to reset values.
    hresetn <= 1'b0;
    @(posedge hclk);
    `CHK({irq, core_request, hrdata}, 41'h0)
    hresetn <= 1'b1;
    @(posedge hclk);
    rchk(ifm_pkg::ADDR_MASK, 32'h0000_00ff);
    rchk(ifm_pkg::ADDR_FLAGS, 32'h0);
    finish_test();
  end
endmodule : ifm_top_tb
bind ifm_top ifm_top_asserts chk_u (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .core_request(core_request),
  .irq(irq));
